// ### include/sto_defines.svh
// constants for the dual channel torque-off monitor
// What this block does
// RULE1 - config bit 8 enables dedicated input observation
// RULE2 - wiring versus config mismatch gives 4D/0001
// RULE3 - dedicated request during servo on gives 0002
// RULE4 - channel mismatch gives 0004 off, 0006 on
// RULE5 - errors clear only on controller reset
// RULE6 - power shut off by request gives A4/0001
// RULE7 - warning clears itself when cause ends
// RULE8 - report code, axis and sub-number
// RULE9 - communication error raises safety communication alarm
// RULE10 - brake channel disagreement raises alarm V07
// RULE11 - either alarm removes motor power
// RULE12 - brake request same cycle as accepted request
// RULE13 - programmable delay before power removal
// RULE14 - axis switch sampled at power-on, 0..F
// RULE15 - supply switch: 0 normal, 4 external stop
// RULE16 - configuration switches captured at power-on only
// RULE17 - safety device holds inputs 600 ms, chatter 1 ms; the mismatch check has no chatter filter, STO_CHATTER_CYC is unused
// RULE18 - two-stage synchroniser on each torque-off input
`ifndef STO_DEFINES_SVH
`define STO_DEFINES_SVH
`define STO_CFG_DEDICATED_BIT 8
`define STO_ERR_CODE 8'h4D
`define STO_WARN_CODE 8'hA4
`define STO_SUB_NONE 16'h0000
`define STO_SUB_WIRING 16'h0001
`define STO_SUB_ILLEGAL 16'h0002
`define STO_SUB_MISMATCH_OFF 16'h0004
`define STO_SUB_MISMATCH_ON 16'h0006
`define STO_SUB_SHUTOFF 16'h0001
`define STO_DISP_ERR 8'h05
`define STO_DISP_WARN 8'h53
`define STO_PSU_NORMAL 4'h0
`define STO_PSU_EXT_STOP 4'h4
`define STO_CLK_MHZ 250
`define STO_CHATTER_US 1000
`define STO_CHATTER_CYC ((`STO_CHATTER_US * `STO_CLK_MHZ))
`endif

// ### include/sto_pkg.sv
// types shared by the torque-off monitor
package sto_pkg;
   // one alarm or warning report
   typedef struct packed {
      logic active; // report valid
      logic [7:0] code; // 4D or A4
      logic [3:0] axis; // axis index, 0 means first axis
      logic [15:0] sub; // detected factor
   } sto_report_s;
   // power-on switch settings
   typedef struct packed {
      logic [3:0] axis_sw; // axis number switch
      logic [3:0] psu_sw; // supply unit switch
      logic [15:0] cfg_word; // servo_func8_word
   } sto_straps_s;
   typedef enum logic [1:0] {STO_RUN, STO_WAIT, STO_OFF} sto_state_e;
endpackage

// ### hw/sto_monitor.sv
// dual channel torque-off monitor with brake and shutoff sequencing
`timescale 1ns/100ps
`default_nettype none
`include "sto_defines.svh"
module sto_monitor #(
   parameter int DELAY_W = 16 // width of the shutoff delay count
) (
   input wire logic CLK, // 250 MHz clock
   input wire logic NRST, // async reset, active low
   input wire sto_pkg::sto_straps_s STRAPS, // switch banks, caught once
   input wire logic TORQUE_OFF_IN_A, // dedicated channel a, 1 = request
   input wire logic TORQUE_OFF_IN_B, // dedicated channel b, 1 = request
   input wire logic PLUG_PRESENT, // short-circuit plug fitted
   input wire logic SERVO_ON, // servo is switched on
   input wire logic NC_TORQUE_OFF_REQ, // controller torque-off request level
   input wire logic [DELAY_W-1:0] SHUTOFF_DELAY_TIME, // delay in cycles
   input wire logic CONTROLLER_RESET_CLEAR, // clear latched errors pulse
   input wire logic COMM_ERROR, // communication path error
   input wire logic BRAKE_CH_A, // brake channel a state
   input wire logic BRAKE_CH_B, // brake channel b state
   output logic BRAKE_REQ, // motor brake request
   output logic POWER_ENABLE, // motor power permitted
   output logic SAFETY_COMM_ALARM, // safety communication alarm
   output logic BRAKE_DIAG_ALARM, // brake circuit alarm V07
   output sto_pkg::sto_report_s ERROR_REPORT, // S05 report
   output sto_pkg::sto_report_s WARNING_REPORT, // S53 report
   output logic PSU_EXT_STOP, // supply set for external stop
   output logic PSU_SW_BAD // prohibited supply switch value
);
   import sto_pkg::*;

   // two-stage synchroniser state, one pair per channel
   logic [1:0] sync_a_reg; // channel a stages
   logic [1:0] sync_a_next; // channel a shifted in
   logic [1:0] sync_b_reg; // channel b stages
   logic [1:0] sync_b_next; // channel b shifted in
   // power-on capture of the switch banks
   logic captured_reg; // straps already taken
   logic captured_next; // set after the first edge
   sto_straps_s straps_reg; // held switch settings
   sto_straps_s straps_next; // settings to hold
   // latched error factor, zero means no error
   logic [15:0] err_sub_reg; // first detected factor
   logic [15:0] err_sub_next; // factor after this edge
   // sticky alarms of the diagnosis paths
   logic comm_alarm_reg; // safety communication alarm
   logic comm_alarm_next; // comm alarm after this edge
   logic brk_alarm_reg; // brake circuit alarm
   logic brk_alarm_next; // brake alarm after this edge
   // controller torque-off sequence
   sto_state_e state_reg; // run, wait or off
   sto_state_e state_next; // state after this edge
   logic [DELAY_W-1:0] cnt_reg; // remaining delay cycles
   logic [DELAY_W-1:0] cnt_next; // count after this edge
   logic shut_reg; // power removed by request
   logic shut_next; // shutoff after this edge
   // brake request held while the sequence runs
   logic brake_reg; // brake request flop
   logic brake_next; // brake request after this edge
   // decoded conditions, all but err_clear and err_base taken from registers
   logic a_s; // synchronised channel a
   logic b_s; // synchronised channel b
   logic ded_req; // both channels request
   logic dedicated; // dedicated observation on
   logic checking; // straps held, checks live
   logic err_clear; // reset command this cycle
   logic [15:0] err_base; // factor left after a clear
   logic warn_active; // torque-off warning cause present

   // choose a sub-number, keeps the first detected factor
   function automatic logic [15:0] pick(input logic [15:0] cur, input logic [15:0] cand);
      pick = (cur != `STO_SUB_NONE) ? cur : cand;
   endfunction

   // compare the held supply switch with one setting
   function automatic logic psu_is(input logic [3:0] sw, input logic [3:0] val);
      psu_is = (sw == val);
   endfunction

   // decoded conditions shared by the error and output logic
   always_comb begin
      // RULE18 only the second stage is read
      a_s = sync_a_reg[1];
      b_s = sync_b_reg[1];
      // both channels ask for torque off
      ded_req = a_s & b_s;
      // RULE1 config bit 8 selects observation
      dedicated = straps_reg.cfg_word[`STO_CFG_DEDICATED_BIT];
      // checks wait until the switches are held
      checking = captured_reg;
      // reset command from the controller
      err_clear = CONTROLLER_RESET_CLEAR;
      // a clear empties the slot before new factors
      if (err_clear) begin
         err_base = `STO_SUB_NONE;
      end else begin
         err_base = err_sub_reg;
      end
   end

   // RULE18 shift each raw input into its own two stages
   always_comb begin
      sync_a_next = {sync_a_reg[0], TORQUE_OFF_IN_A};
      sync_b_next = {sync_b_reg[0], TORQUE_OFF_IN_B};
   end

   // synchroniser registers, cleared to no request
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         sync_a_reg <= 2'h0;
         sync_b_reg <= 2'h0;
      end else begin
         sync_a_reg <= sync_a_next;
         sync_b_reg <= sync_b_next;
      end
   end

   // RULE16 take the switch banks once, on the first edge
   always_comb begin
      captured_next = 1'b1;
      if (captured_reg) begin
         // later switch changes are ignored
         straps_next = straps_reg;
      end else begin
         // first edge after reset release
         straps_next = STRAPS;
      end
   end

   // power-on capture registers
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         captured_reg <= 1'b0;
         straps_reg <= '0;
      end else begin
         captured_reg <= captured_next;
         straps_reg <= straps_next;
      end
   end

   // latched error factor, first detected factor wins
   always_comb begin
      // RULE5 only the reset command clears, set beats clear
      err_sub_next = err_base;
      if (checking) begin
         // RULE2 wiring disagrees with config
         if (dedicated == PLUG_PRESENT) begin
            err_sub_next = pick(err_base, `STO_SUB_WIRING);
         // RULE4 channel mismatch, servo state picks code
         end else if (dedicated && (a_s != b_s)) begin
            if (SERVO_ON) begin
               err_sub_next = pick(err_base, `STO_SUB_MISMATCH_ON);
            end else begin
               err_sub_next = pick(err_base, `STO_SUB_MISMATCH_OFF);
            end
         // RULE3 dedicated request during servo on
         end else if (dedicated && ded_req && SERVO_ON) begin
            err_sub_next = pick(err_base, `STO_SUB_ILLEGAL);
         end
      end
   end

   // error factor register, empty after reset
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         err_sub_reg <= `STO_SUB_NONE;
      end else begin
         err_sub_reg <= err_sub_next;
      end
   end

   // sticky alarms, cleared only by the reset command
   always_comb begin
      if (err_clear) begin
         // reset command drops both alarms
         comm_alarm_next = 1'b0;
         brk_alarm_next = 1'b0;
      end else begin
         // otherwise they hold
         comm_alarm_next = comm_alarm_reg;
         brk_alarm_next = brk_alarm_reg;
      end
      // RULE9 communication error raises the alarm
      if (COMM_ERROR) begin
         comm_alarm_next = 1'b1;
      end
      // RULE10 brake channels must agree
      if (BRAKE_CH_A != BRAKE_CH_B) begin
         brk_alarm_next = 1'b1;
      end
   end

   // alarm registers, quiet after reset
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         comm_alarm_reg <= 1'b0;
         brk_alarm_reg <= 1'b0;
      end else begin
         comm_alarm_reg <= comm_alarm_next;
         brk_alarm_reg <= brk_alarm_next;
      end
   end

   // controller torque-off sequence, next state
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shut_next = shut_reg;
      case (state_reg)
         STO_RUN: begin
            // RULE12 request accepted, delay loaded
            if (NC_TORQUE_OFF_REQ) begin
               state_next = STO_WAIT;
               cnt_next = SHUTOFF_DELAY_TIME;
            end
         end
         STO_WAIT: begin
            // RULE13 wait programmed delay then cut power
            if (!NC_TORQUE_OFF_REQ) begin
               // request withdrawn, abort
               state_next = STO_RUN;
            end else if (cnt_reg == '0) begin
               // delay spent, power goes
               state_next = STO_OFF;
               shut_next = 1'b1;
            end else begin
               // keep counting down
               cnt_next = cnt_reg - 1'b1;
            end
         end
         STO_OFF: begin
            // release when request withdrawn
            if (!NC_TORQUE_OFF_REQ) begin
               state_next = STO_RUN;
               shut_next = 1'b0;
            end
         end
         default: begin
            // unknown state, back to run
            state_next = STO_RUN;
            shut_next = 1'b0;
         end
      endcase
   end

   // sequence registers, idle after reset
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         state_reg <= STO_RUN;
         cnt_reg <= '0;
         shut_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         shut_reg <= shut_next;
      end
   end

   // RULE12 brake stays on while the sequence is away from run
   always_comb begin
      brake_next = NC_TORQUE_OFF_REQ | (state_next != STO_RUN);
   end

   // brake request register, released after reset
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         brake_reg <= 1'b0;
      end else begin
         brake_reg <= brake_next;
      end
   end

   // warning cause, power removed by a correct request
   always_comb begin
      // RULE6 controller shutoff or both dedicated channels
      // RULE7 warning follows cause, no reset needed
      warn_active = shut_reg | (ded_req & checking & (err_sub_reg == `STO_SUB_NONE));
   end

   // outputs
   always_comb begin
      // RULE12 brake follows request in its own cycle
      BRAKE_REQ = NC_TORQUE_OFF_REQ | brake_reg;
      SAFETY_COMM_ALARM = comm_alarm_reg;
      BRAKE_DIAG_ALARM = brk_alarm_reg;
      // RULE11 alarms, errors and requests remove power
      POWER_ENABLE = !(comm_alarm_reg | brk_alarm_reg | shut_reg | (ded_req & checking)
                       | (err_sub_reg != `STO_SUB_NONE));
      // RULE8 code, axis and factor of the error
      ERROR_REPORT.active = (err_sub_reg != `STO_SUB_NONE);
      ERROR_REPORT.code = `STO_ERR_CODE;
      // RULE14 axis index from power-on switch
      ERROR_REPORT.axis = straps_reg.axis_sw;
      ERROR_REPORT.sub = err_sub_reg;
      // RULE8 code, axis and factor of the warning
      WARNING_REPORT.active = warn_active;
      WARNING_REPORT.code = `STO_WARN_CODE;
      WARNING_REPORT.axis = straps_reg.axis_sw;
      if (warn_active) begin
         WARNING_REPORT.sub = `STO_SUB_SHUTOFF;
      end else begin
         WARNING_REPORT.sub = `STO_SUB_NONE;
      end
      // RULE15 supply switch decode, 0 and 4 allowed
      PSU_EXT_STOP = checking & psu_is(straps_reg.psu_sw, `STO_PSU_EXT_STOP);
      PSU_SW_BAD = checking & !psu_is(straps_reg.psu_sw, `STO_PSU_NORMAL)
                   & !psu_is(straps_reg.psu_sw, `STO_PSU_EXT_STOP);
   end
endmodule
`default_nettype wire

// ### tb/sto_chk_monitor.sv
// port assertions for the torque-off monitor
`timescale 1ns/100ps
`default_nettype none
module sto_chk #(
   parameter int DELAY_W = 16 // width of the shutoff delay count
) (
   input wire logic CLK, // in
   input wire logic NRST, // in
   input wire logic NC_TORQUE_OFF_REQ, // in
   input wire logic [DELAY_W-1:0] SHUTOFF_DELAY_TIME, // in
   input wire logic CONTROLLER_RESET_CLEAR, // in
   input wire logic COMM_ERROR, // in
   input wire logic BRAKE_CH_A, // in
   input wire logic BRAKE_CH_B, // in
   input wire logic BRAKE_REQ, // out
   input wire logic POWER_ENABLE, // out
   input wire logic SAFETY_COMM_ALARM, // out
   input wire logic BRAKE_DIAG_ALARM, // out
   input wire sto_pkg::sto_report_s ERROR_REPORT, // out
   input wire sto_pkg::sto_report_s WARNING_REPORT // out
);
   import sto_pkg::*;
   default clocking @(posedge CLK);
   endclocking
   default disable iff (!NRST);
   a_brake_now: assert property (NC_TORQUE_OFF_REQ |-> BRAKE_REQ) else $error("brake");
   a_err_code: assert property (ERROR_REPORT.active |-> ERROR_REPORT.code == 8'h4D) else $error("ecode");
   a_warn_sub: assert property (WARNING_REPORT.active |-> WARNING_REPORT.sub == 16'h0001) else $error("wsub");
   a_err_held: assert property (ERROR_REPORT.active && !CONTROLLER_RESET_CLEAR |=> ERROR_REPORT.active) else $error("e");
   a_comm_alarm: assert property (COMM_ERROR |-> ##[1:2] SAFETY_COMM_ALARM) else $error("comm");
   a_brake_diag: assert property (BRAKE_CH_A != BRAKE_CH_B |-> ##[1:3] BRAKE_DIAG_ALARM) else $error("diag");
   a_alarm_stop: assert property (SAFETY_COMM_ALARM || BRAKE_DIAG_ALARM |-> !POWER_ENABLE) else $error("stop");
   a_delay_hold: assert property ($rose(NC_TORQUE_OFF_REQ) && POWER_ENABLE && ((SHUTOFF_DELAY_TIME >> 1) != '0)
      |=> POWER_ENABLE [*2]) else $error("cut");
   c_warn: cover property (WARNING_REPORT.active);
   c_mis_on: cover property (ERROR_REPORT.sub == 16'h0006);
   c_diag: cover property (BRAKE_DIAG_ALARM);
endmodule
bind sto_monitor sto_chk #(.DELAY_W(DELAY_W)) i_sto_chk (.CLK, .NRST, .NC_TORQUE_OFF_REQ, .SHUTOFF_DELAY_TIME,
   .CONTROLLER_RESET_CLEAR, .COMM_ERROR, .BRAKE_CH_A, .BRAKE_CH_B, .BRAKE_REQ, .POWER_ENABLE, .SAFETY_COMM_ALARM,
   .BRAKE_DIAG_ALARM, .ERROR_REPORT, .WARNING_REPORT);
`default_nettype wire

// ### tb/sto_partner.sv
// model of the controller and the external safety switch
`timescale 1ns/100ps
`default_nettype none
module sto_partner (
   input wire logic CLK, // clock
   input wire logic nc_stop, // controller stop wish
   input wire logic ded_stop, // switch stop wish
   input wire logic break_b, // fault on channel b
   output logic nc_req, // controller request
   output logic sto_a, // torque_off_in_a
   output logic sto_b, // torque_off_in_b
   output logic [15:0] delay // shutoff_delay_time
);
   int cnt = 0; // level hold counter
   logic a_reg = 1'b0; // switch contact a level
   assign sto_a = a_reg;
   assign delay = 16'h0004;
   assign nc_req = nc_stop;
   assign sto_b = sto_a ^ break_b;
   always @(posedge CLK) begin
      if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if (ded_stop != a_reg) begin
         a_reg <= ded_stop;
         cnt <= 20;
      end
   end
endmodule
`default_nettype wire

// ### tb/testbench.sv
// bench for the torque-off monitor
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import sto_pkg::*;
   logic clk = 0, nrst = 0, plug = 0, srv = 0, clr = 0, cm = 0, ba = 0, bb = 0, nc = 0, ds = 0, bk = 0;
   logic rq, a, b, brk, pwr, ca, da, ext, bad;
   logic [15:0] dly;
   sto_straps_s st = {4'h9, 4'h4, 16'h0100};
   sto_report_s er, wr;
   int miscompares = 0, checks = 0;
   always #2 clk = ~clk;
   sto_partner i_sto_partner (.CLK(clk), .nc_stop(nc), .ded_stop(ds), .break_b(bk), .nc_req(rq), .sto_a(a),
      .sto_b(b), .delay(dly));
   sto_monitor i_sto_monitor (.CLK(clk), .NRST(nrst), .STRAPS(st), .TORQUE_OFF_IN_A(a), .TORQUE_OFF_IN_B(b),
      .PLUG_PRESENT(plug), .SERVO_ON(srv), .NC_TORQUE_OFF_REQ(rq), .SHUTOFF_DELAY_TIME(dly),
      .CONTROLLER_RESET_CLEAR(clr), .COMM_ERROR(cm), .BRAKE_CH_A(ba), .BRAKE_CH_B(bb), .BRAKE_REQ(brk),
      .POWER_ENABLE(pwr), .SAFETY_COMM_ALARM(ca), .BRAKE_DIAG_ALARM(da), .ERROR_REPORT(er),
      .WARNING_REPORT(wr), .PSU_EXT_STOP(ext), .PSU_SW_BAD(bad));
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic clear;
      clr = 1;
      cyc(1);
      clr = 0;
      cyc(1);
   endtask
   task automatic t_nc;
      st = {4'h3, 4'h2, 16'h0000};
      chk("ext", 1, ext);
      chk("bad", 0, bad);
      nc = 1;
      #1 chk("brake", 1, brk);
      cyc(3);
      chk("pwr_wait", 1, pwr);
      cyc(6);
      chk("pwr_off", 0, pwr);
      chk("warn", {1'h1, 8'hA4, 4'h9, 16'h0001}, wr);
      nc = 0;
      cyc(2);
      chk("warn_gone", 0, wr.active);
      $display("test nc done");
   endtask
   task automatic t_mis(input logic on, input logic [15:0] sub);
      srv = on;
      bk = 1;
      cyc(5);
      chk("mis_sub", sub, er.sub);
      bk = 0;
      cyc(5);
      chk("mis_held", 1, er.active);
      clear();
      chk("mis_clr", 0, er.active);
      srv = 0;
      $display("test mismatch done");
   endtask
   task automatic t_ill;
      ds = 1;
      cyc(6);
      chk("ded_warn", 1, wr.active);
      chk("ded_pwr", 0, pwr);
      srv = 1;
      cyc(2);
      chk("ill_rep", {1'h1, 8'h4D, 4'h9, 16'h0002}, er);
      ds = 0;
      srv = 0;
      cyc(26);
      clear();
      chk("ill_clr", 0, er.active);
      chk("ill_warn", 0, wr.active);
      plug = 1;
      cyc(4);
      chk("wire_sub", 16'h0001, er.sub);
      plug = 0;
      clear();
      $display("test illegal done");
   endtask
   task automatic t_alarm;
      cm = 1;
      cyc(1);
      cm = 0;
      cyc(3);
      chk("comm", 1, ca);
      chk("comm_pwr", 0, pwr);
      clear();
      chk("comm_clr", 0, ca);
      ba = 1;
      bb = 1;
      cyc(4);
      chk("diag_same", 0, da);
      bb = 0;
      cyc(4);
      chk("diag", 1, da);
      ba = 0;
      clear();
      chk("diag_clr", 0, da);
      $display("test alarm done");
   endtask
   task automatic t_rst;
      nrst = 0;
      cyc(12);
      nrst = 1;
      cyc(3);
      chk("psu_bad", 1, bad);
      chk("psu_ext", 0, ext);
      chk("plug_rep", {1'h1, 8'h4D, 4'h3, 16'h0001}, er);
      plug = 1;
      clear();
      chk("plug_clr", 0, er.active);
      $display("test reset done");
   endtask
   task automatic finish_test;
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      cyc(12);
      nrst = 1;
      cyc(3);
      t_nc();
      t_mis(1'h0, 16'h0004);
      t_mis(1'h1, 16'h0006);
      t_ill();
      t_alarm();
      t_rst();
      finish_test();
   end
   initial begin
      #5000;
      miscompares++;
      finish_test();
   end
endmodule
`default_nettype wire
